// >>> emb_bank_map.sv
// external memory interface: bank select, address generation and piece sequencing
`include "emb_map.svh"
`default_nettype none
module emb_bank_map (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [31:0] ext_mem_ctl_reg,
  input wire logic [3:0] bank_sdram,
  input wire logic req_valid,
  output logic req_ready,
  input wire emb_pkg::emb_req_t req,
  output logic resp_valid,
  output logic resp_err,
  output emb_pkg::emb_src_t resp_src,
  output logic [31:0] resp_rdata,
  output logic [3:0] bank_select_lines_n,
  output logic [23:0] ext_addr_bus,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic [31:0] ext_data_o,
  output logic ext_data_oe,
  input wire logic [31:0] ext_data_i,
  output emb_pkg::emb_sdram_t sdram_addr,
  output logic sdram_addr_valid
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STROBE,
    ST_GAP
  } emb_state_t;

  emb_state_t state_q;
  logic [3:0] cnt_q;
  logic [1:0] piece_q;
  logic [1:0] last_q;
  logic [23:0] base_q;
  logic [31:0] wdata_q;
  logic we_q;
  emb_pkg::emb_mode_t mode_q;

  // mode from the control word
  wire [1:0] bus_width_field = ext_mem_ctl_reg[`EMB_BW_MSB:`EMB_BW_LSB];
  wire pack_disable = ext_mem_ctl_reg[`EMB_PACK_DIS_BIT];
  wire narrow = (bus_width_field == `EMB_BW_16) || (bus_width_field == `EMB_BW_8);
  wire emb_pkg::emb_mode_t mode = (!narrow || pack_disable) ? emb_pkg::EMB_MODE_W32 :
      (bus_width_field == `EMB_BW_16) ? emb_pkg::EMB_MODE_P16 :
      emb_pkg::EMB_MODE_P8;
  wire [1:0] last_piece = (mode == emb_pkg::EMB_MODE_P16) ? `EMB_LAST_P16 :
      (mode == emb_pkg::EMB_MODE_P8) ? `EMB_LAST_P8 : `EMB_LAST_W32;

  wire [3:0] bank_hit;
  wire [23:0] ext_base;
  emb_pkg::emb_sdram_t sd_split;

  emb_xaddr u_xaddr (
    .addr(req.addr),
    .bank_sdram(bank_sdram),
    .mode(mode),
    .bank_hit(bank_hit),
    .ext_base(ext_base),
    .sdram(sd_split)
  );

  // acceptance and legality
  assign req_ready = (state_q == ST_IDLE);
  // core and dma requests take the same path
  wire accept = req_valid && req_ready;
  wire width_ok = (req.width == emb_pkg::EMB_WD_NORMAL);
  wire no_fetch = !req.ifetch;
  wire mapped = |bank_hit;
  wire legal = width_ok && no_fetch && mapped;
  wire [3:0] sdram_hit = bank_hit & bank_sdram;

  // piece stepping
  wire strobe_end = (state_q == ST_STROBE) && (cnt_q == 4'h0);
  wire last_done = strobe_end && (piece_q == last_q);
  wire [1:0] piece_nx = piece_q + 2'h1;
  wire [4:0] sh_cur = (mode_q == emb_pkg::EMB_MODE_P16) ? {piece_q[0], 4'h0} :
                      {piece_q, 3'h0};
  wire [4:0] sh_nx = (mode_q == emb_pkg::EMB_MODE_P16) ? {piece_nx[0], 4'h0} :
                     {piece_nx, 3'h0};
  wire [3:0] strobe_load = 4'(`EMB_STROBE_CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && legal) begin
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (last_done) begin
            state_q <= ST_IDLE;
          end else if (strobe_end) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          state_q <= ST_STROBE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // transfer context
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      piece_q <= 2'h0;
      last_q <= 2'h0;
      base_q <= 24'h0;
      wdata_q <= 32'h0;
      we_q <= 1'b0;
      mode_q <= emb_pkg::EMB_MODE_W32;
    end else if (accept && legal) begin
      cnt_q <= strobe_load;
      piece_q <= 2'h0;
      last_q <= last_piece;
      base_q <= ext_base;
      wdata_q <= req.wdata;
      we_q <= req.we;
      mode_q <= mode;
    end else if (state_q == ST_STROBE && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (strobe_end && !last_done) begin
      cnt_q <= strobe_load;
      piece_q <= piece_nx;
    end
  end

  // external pins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bank_select_lines_n <= 4'hf;
      ext_addr_bus <= 24'h0;
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      ext_data_o <= 32'h0;
      ext_data_oe <= 1'b0;
    end else if (accept && legal) begin
      bank_select_lines_n <= ~bank_hit;
      ext_addr_bus <= ext_base;
      ext_rd_n <= req.we;
      ext_wr_n <= !req.we;
      ext_data_o <= req.wdata;
      ext_data_oe <= req.we;
    end else if (last_done) begin
      bank_select_lines_n <= 4'hf;
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      ext_data_oe <= 1'b0;
    end else if (strobe_end) begin
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      ext_addr_bus <= base_q | {22'h0, piece_nx};
      ext_data_o <= wdata_q >> sh_nx;
    end else if (state_q == ST_GAP) begin
      ext_rd_n <= we_q;
      ext_wr_n <= !we_q;
    end
  end

  // read assembly and answer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_src <= emb_pkg::EMB_SRC_CORE;
      resp_rdata <= 32'h0;
      sdram_addr <= '0;
      sdram_addr_valid <= 1'b0;
    end else begin
      resp_valid <= (accept && !legal) || last_done;
      if (accept) begin
        resp_err <= !legal;
        resp_src <= req.src;
        resp_rdata <= 32'h0;
        sdram_addr <= sd_split;
        sdram_addr_valid <= legal && (|sdram_hit);
      end else if (strobe_end && !we_q) begin
        if (mode_q == emb_pkg::EMB_MODE_W32) begin
          resp_rdata <= ext_data_i;
        end else if (mode_q == emb_pkg::EMB_MODE_P16) begin
          resp_rdata[sh_cur +: 16] <= ext_data_i[15:0];
        end else begin
          resp_rdata[sh_cur +: 8] <= ext_data_i[7:0];
        end
      end
      if (last_done) begin
        sdram_addr_valid <= 1'b0;
      end
    end
  end
endmodule : emb_bank_map
`default_nettype wire

// >>> emb_bank_map_chk.sv
// assertions on the ports of the external memory bank map
`default_nettype none
module emb_bank_map_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire emb_pkg::emb_req_t req,
  input wire logic resp_valid,
  input wire logic resp_err,
  input wire logic [3:0] bank_select_lines_n,
  input wire logic [23:0] ext_addr_bus,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire emb_pkg::emb_sdram_t sdram_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic acc = req_valid && req_ready;
  wire logic st = ext_rd_n && ext_wr_n;
  a_sel_one_hot: assert property ($onehot0(~bank_select_lines_n))
    else $error("more than one bank select low");
  a_strobe_sel: assert property (
    !st |-> bank_select_lines_n != 4'hf && ext_rd_n != ext_wr_n) else $error("stray strobe");
  a_bad_width: assert property (
    acc && req.width != emb_pkg::EMB_WD_NORMAL |=> resp_valid && resp_err) else $error("width");
  a_no_fetch: assert property (
    acc && req.ifetch |=> resp_valid && resp_err && bank_select_lines_n == 4'hf)
    else $error("fetch not refused");
  a_strobe_len: assert property ($fell(st) |=> !st ##1 st)
    else $error("strobe length");
  a_addr_hold: assert property ($fell(st) |=> $stable(ext_addr_bus))
    else $error("address moved in strobe");
  a_piece_step: assert property (
    $rose(st) && bank_select_lines_n != 4'hf |-> ext_addr_bus == $past(ext_addr_bus) + 24'h1)
    else $error("piece address step");
  a_sdram_split: assert property (acc |=> sdram_addr ==
    {$past(req.addr[22:10]), $past(req.addr[7:0]), $past(req.addr[9:8])}) else $error("split");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response longer than a cycle");
  a_busy_strobe: assert property (!st |-> !req_ready)
    else $error("ready during strobe");
endmodule : emb_bank_map_chk
bind emb_bank_map emb_bank_map_chk u_chk (.clk_sys, .sys_rst, .req_valid, .req_ready, .req,
  .resp_valid, .resp_err, .bank_select_lines_n, .ext_addr_bus, .ext_rd_n, .ext_wr_n,
  .sdram_addr);
`default_nettype wire

// >>> emb_map.svh
// constants for the external memory bank decode and address generation
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH

// control word fields
`define EMB_BW_MSB 2
`define EMB_BW_LSB 1
`define EMB_PACK_DIS_BIT 4

// bus width field codes
`define EMB_BW_8 2'h0
`define EMB_BW_16 2'h1
`define EMB_BW_32 2'h2

// bank ranges
`define EMB_BANK0_START 32'h0020_0000
`define EMB_BANK_STRIDE 32'h0400_0000
`define EMB_ASYNC_SPAN 32'h0100_0000
`define EMB_SDRAM_SPAN 32'h0400_0000

// sdram split of the internal address
`define EMB_SD_COL_MSB 7
`define EMB_SD_COL_LSB 0
`define EMB_SD_IBANK_MSB 9
`define EMB_SD_IBANK_LSB 8
`define EMB_SD_ROW_MSB 22
`define EMB_SD_ROW_LSB 10

// piece counts less one
`define EMB_LAST_W32 2'h0
`define EMB_LAST_P16 2'h1
`define EMB_LAST_P8 2'h3

// strobe timing
`define EMB_CLK_MHZ 200
`define EMB_STROBE_NS 10
`define EMB_STROBE_CYC ((`EMB_STROBE_NS * `EMB_CLK_MHZ + 999) / 1000)

`endif

// >>> emb_mem_model.sv
// external memory device answering strobes on the external bus
`default_nettype none
module emb_mem_model (
  input wire logic clk_sys,
  input wire logic [3:0] sel_n,
  input wire logic [23:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [31:0] din,
  input wire logic [31:0] mask,
  output logic [31:0] dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [64];
  wire logic cs = sel_n != 4'hf;
  initial begin
    dout = 32'h0;
    for (int i = 0; i < 64; i++) mem[i] = 32'h9e37_79b9 * (i + 1);
  end
  // stores only the bus width; drives toggling junk when not read
  always @(posedge clk_sys) begin
    if (cs && !wr_n) mem[addr[5:0]] <= din & mask;
    dout <= (cs && !rd_n) ? mem[addr[5:0]] : ~dout;
  end
endmodule : emb_mem_model
`default_nettype wire

// >>> emb_pkg.sv
// types for the external memory bank decode and address generation
`default_nettype none
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_WD_NORMAL,
    EMB_WD_EXTENDED,
    EMB_WD_SHORT,
    EMB_WD_LONG
  } emb_width_t;

  typedef enum logic {
    EMB_SRC_CORE,
    EMB_SRC_DMA
  } emb_src_t;

  typedef enum logic [1:0] {
    EMB_MODE_W32,
    EMB_MODE_P16,
    EMB_MODE_P8
  } emb_mode_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic we;
    emb_src_t src;
    emb_width_t width;
    logic ifetch;
  } emb_req_t;

  typedef struct packed {
    logic [12:0] row;
    logic [7:0] col;
    logic [1:0] ibank;
  } emb_sdram_t;
endpackage : emb_pkg
`default_nettype wire

// >>> emb_xaddr.sv
// bank range decode, external base address and sdram address split
`include "emb_map.svh"
`default_nettype none
module emb_xaddr (
  input wire logic [31:0] addr,
  input wire logic [3:0] bank_sdram,
  input wire emb_pkg::emb_mode_t mode,
  output logic [3:0] bank_hit,
  output logic [23:0] ext_base,
  output emb_pkg::emb_sdram_t sdram
);
  function automatic logic bank_hit_f(input logic [31:0] a, input logic [1:0] k,
                                      input logic is_sd);
    logic [31:0] base;
    logic [31:0] lo;
    logic [31:0] hi;
    base = `EMB_BANK_STRIDE * {30'h0, k};
    lo = (k == 2'h0) ? `EMB_BANK0_START : base;
    hi = base + (is_sd ? `EMB_SDRAM_SPAN : `EMB_ASYNC_SPAN) - 32'h1;
    return (a >= lo) && (a <= hi);
  endfunction : bank_hit_f

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bank
      // async span 16M words, sdram span 64M words
      assign bank_hit[gi] = bank_hit_f(addr, 2'(gi), bank_sdram[gi]);
    end
  endgenerate

  // packed modes shift the word address up to leave room for the piece index
  wire [23:0] base_w32 = addr[23:0];
  wire [23:0] base_p16 = {addr[22:0], 1'b0};
  wire [23:0] base_p8 = {addr[21:0], 2'b00};
  assign ext_base = (mode == emb_pkg::EMB_MODE_P16) ? base_p16 :
                    (mode == emb_pkg::EMB_MODE_P8) ? base_p8 : base_w32;

  assign sdram.row = addr[`EMB_SD_ROW_MSB:`EMB_SD_ROW_LSB];
  assign sdram.col = addr[`EMB_SD_COL_MSB:`EMB_SD_COL_LSB];
  assign sdram.ibank = addr[`EMB_SD_IBANK_MSB:`EMB_SD_IBANK_LSB];
endmodule : emb_xaddr
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the external memory bank map
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, sys_rst, req_valid, req_ready, resp_valid, resp_err, rd_n, wr_n, oe, sdv;
  logic [31:0] ctl, mask, rdata, din, dout;
  logic [3:0] sdr, sel_n;
  logic [23:0] ea;
  emb_pkg::emb_req_t req;
  emb_pkg::emb_src_t src;
  int miscompares, check_count;
  logic [31:0] bm [64];
  emb_bank_map dut (.clk_sys, .sys_rst, .ext_mem_ctl_reg(ctl), .bank_sdram(sdr), .req_valid,
    .req_ready, .req, .resp_valid, .resp_err, .resp_src(src), .resp_rdata(rdata),
    .bank_select_lines_n(sel_n), .ext_addr_bus(ea), .ext_rd_n(rd_n), .ext_wr_n(wr_n),
    .ext_data_o(din), .ext_data_oe(oe), .ext_data_i(dout), .sdram_addr(),
    .sdram_addr_valid(sdv));
  emb_mem_model mem (.clk_sys, .sel_n, .addr(ea), .rd_n, .wr_n, .din, .mask, .dout);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  function automatic int bank_of(input logic [31:0] a);
    logic [31:0] lo;
    logic [31:0] hi;
    for (int k = 0; k < 4; k++) begin
      lo = k * 32'h0400_0000 + (k == 0 ? 32'h0020_0000 : 0);
      hi = k * 32'h0400_0000 + (sdr[k] ? 32'h0400_0000 : 32'h0100_0000) - 1;
      if (a >= lo && a <= hi) return k;
    end
    return 4;
  endfunction : bank_of
  task automatic xfer(input logic [31:0] a, input logic we, input logic [1:0] wd, input logic f);
    int p, w, b, n;
    logic bad;
    logic [23:0] base;
    logic [31:0] d, m, exp;
    @(posedge clk_sys);
    p = (ctl[4] || ctl[2:1] > 2'h1) ? 1 : (ctl[2:1] == 2'h1 ? 2 : 4);
    w = 32 / p;
    m = (32'h1 << w) - 32'h1;
    base = (p == 1) ? a[23:0] : (p == 2) ? {a[22:0], 1'b0} : {a[21:0], 2'b00};
    b = bank_of(a);
    bad = wd != 2'h0 || f || b == 4;
    d = $urandom;
    exp = 0;
    req_valid <= 1'b1;
    req <= '{a, d, we, emb_pkg::emb_src_t'(a[0]), emb_pkg::emb_width_t'(wd), f};
    mask <= m;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (int k = 0; k < p && !bad; k++) begin
      if (we) bm[(base | k) & 63] = (d >> (k * w)) & m;
      else exp |= (bm[(base | k) & 63] & m) << (k * w);
    end
    n = 0;
    #1;
    chk(sel_n, bad ? 4'hf : 4'(~(4'h1 << b)));
    chk({rd_n, wr_n}, bad ? 2'h3 : {we, !we});
    chk(oe, !bad && we);
    chk(sdv, bad ? 1'b0 : sdr[b]);
    if (!bad) chk(ea, base);
    if (!bad && we) chk(din, d);
    while (resp_valid !== 1'b1 && n <= 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n > 40) begin
      miscompares++;
      results();
    end
    chk(n, bad ? 0 : 3 * p - 1);
    chk(resp_err, bad);
    chk(rdata, (we || bad) ? 32'h0 : exp);
    chk(src, a[0]);
  endtask : xfer
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    logic [31:0] cs [6];
    logic [31:0] c;
    int k;
    cs = '{0, 32'h1f_ffff, 32'h20_0000, 32'hff_ffff, 32'h100_0000, 32'h3ff_ffff};
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    ctl = 32'h0;
    sdr = 4'h0;
    mask = 32'hffff_ffff;
    miscompares = 0;
    check_count = 0;
    for (int i = 0; i < 64; i++) bm[i] = 32'h9e37_79b9 * (i + 1);
    void'($urandom(32'h1c1b9cc3));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk({sel_n, rd_n, wr_n, req_ready, resp_valid}, 8'hfe);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      ctl <= {27'h0, i > 3, 1'b0, 2'(i % 4), 1'b0};
      sdr <= 4'($urandom);
      repeat (40) begin
        k = $urandom % 5;
        c = ($urandom % 9 < 6) ? cs[$urandom % 6] : $urandom % 32'h0400_0000;
        xfer((k << 26) + c, 1'($urandom), ($urandom % 4 == 0) ? 2'($urandom) : 2'h0,
          $urandom % 8 == 0);
      end
    end
    results();
  end
endmodule : tb_top
`default_nettype wire
